//--- rtl/keyboard_interrupt_unit.sv
// Keypad wake unit: APB registers, pin detection and shared request latch
`timescale 1ns/1ps
`include "keyboard_interrupt_unit_cfg.svh"
module keyboard_interrupt_unit
#(
    parameter int NUM_PINS = 5,
    parameter int ADDR_W = 12
)
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire keyboard_interrupt_unit_pkg::apb_word_t PWDATA,
    input wire logic [3:0] PSTRB,
    output keyboard_interrupt_unit_pkg::apb_word_t PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [NUM_PINS-1:0] KEYPAD_INPUT_PINS,
    input wire logic [NUM_PINS-1:0] PORT_DIR,
    input wire logic VECTOR_FETCH,
    input wire logic BREAK_STATE,
    input wire logic BREAK_CLEAR_ENABLE,
    output logic KEY_IRQ,
    output logic [NUM_PINS-1:0] PULLUP_EN,
    output logic [NUM_PINS-1:0] PULLDOWN_EN,
    output logic [NUM_PINS-1:0] PIN_DRIVE_EN
);
    import keyboard_interrupt_unit_pkg::*;

    sense_t sensitivity_select;
    logic request_mask;
    logic [NUM_PINS-1:0] pin_enable_bits;
    logic [NUM_PINS-1:0] pin_polarity_bits;
    logic [NUM_PINS-1:0] synced;
    logic [NUM_PINS-1:0] asserted;
    logic any_asserted;
    logic any_prev;
    logic key_latch;
    logic pending_flag;
    logic set_event;
    logic clear_allowed;
    logic acknowledge;
    logic ack_write;
    logic bus_write;
    logic lane0_write;
    reg_sel_t reg_sel;
    apb_word_t next_rdata;

    // Per-pin synchroniser and detector
    genvar g;
    generate
        for (g = 0; g < NUM_PINS; g++)
        begin : g_pin
            pin_sync u_sync
            (
                .clk(CLOCK),
                .rst_b(RST_B),
                .d(KEYPAD_INPUT_PINS[g]),
                .q(synced[g])
            );
            key_pin_channel u_chan
            (
                .clk(CLOCK),
                .rst_b(RST_B),
                .level(synced[g]),
                .enable(pin_enable_bits[g]),
                .polarity(pin_polarity_bits[g]),
                .asserted(asserted[g]),
                .pull_up(PULLUP_EN[g]),
                .pull_down(PULLDOWN_EN[g])
            );
        end
    endgenerate

    // Address decode, one aligned word per register
    always_comb
    begin
        case (PADDR)
            `KEY_STATUS_CONTROL_OFFSET: reg_sel = SEL_STATUS;
            `KEY_PIN_ENABLE_OFFSET: reg_sel = SEL_ENABLE;
            `KEY_PIN_POLARITY_OFFSET: reg_sel = SEL_POLARITY;
            default: reg_sel = SEL_NONE;
        endcase
    end

    // Zero wait states; unmapped addresses answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & (reg_sel == SEL_NONE);
    assign bus_write = PSEL & PENABLE & PWRITE;
    // All registers live in byte lane 0
    assign lane0_write = bus_write & PSTRB[0];

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sensitivity_select <= SENSE_EDGE;
            request_mask <= `REQUEST_MASK_RESET;
        end
        else if (lane0_write && reg_sel == SEL_STATUS)
        begin
            sensitivity_select <=
                sense_t'(PWDATA[`SENSITIVITY_SELECT_BIT]);
            request_mask <= PWDATA[`REQUEST_MASK_BIT];
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            pin_enable_bits <= NUM_PINS'(`KEY_PIN_ENABLE_RESET);
        else if (lane0_write && reg_sel == SEL_ENABLE)
            pin_enable_bits <= PWDATA[NUM_PINS-1:0];
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            pin_polarity_bits <= NUM_PINS'(`KEY_PIN_POLARITY_RESET);
        else if (lane0_write && reg_sel == SEL_POLARITY)
            pin_polarity_bits <= PWDATA[NUM_PINS-1:0];
    end

    // Read data sampled in the setup cycle, held through the access
    always_comb
    begin
        next_rdata = '0;
        case (reg_sel)
            SEL_STATUS:
            begin
                next_rdata[`PENDING_FLAG_BIT] = pending_flag;
                next_rdata[`REQUEST_MASK_BIT] = request_mask;
                next_rdata[`SENSITIVITY_SELECT_BIT] =
                    sensitivity_select;
            end
            SEL_ENABLE: next_rdata[NUM_PINS-1:0] = pin_enable_bits;
            SEL_POLARITY: next_rdata[NUM_PINS-1:0] = pin_polarity_bits;
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            PRDATA <= '0;
        else if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= next_rdata;
    end

    // Acknowledge from software write or vector fetch
    assign ack_write = lane0_write && reg_sel == SEL_STATUS &&
        PWDATA[`REQUEST_ACKNOWLEDGE_BIT];
    // Break protects the latch unless clear-enable is set; a clear made
    // then holds until the next rising edge of the OR of all inputs sets the latch again
    assign clear_allowed = ~BREAK_STATE | BREAK_CLEAR_ENABLE;
    assign acknowledge = (ack_write | VECTOR_FETCH) & clear_allowed;

    // The OR of all inputs is edge detected, so a second pin going active
    // while another is still asserted makes no new edge
    assign any_asserted = |asserted;
    assign set_event = any_asserted & ~any_prev;

    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            any_prev <= 1'b0;
        else
            any_prev <= any_asserted;
    end

    // Set wins over a clear in the same cycle so no edge is lost
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            key_latch <= 1'b0;
        else if (set_event)
            key_latch <= 1'b1;
        else if (acknowledge)
            key_latch <= 1'b0;
    end

    // Level term keeps the request alive until all inputs deassert
    assign pending_flag = key_latch |
        ((sensitivity_select == SENSE_EDGE_LEVEL) & any_asserted);

    // Same output serves as wake request in wait and stop
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            KEY_IRQ <= 1'b0;
        else
            KEY_IRQ <= pending_flag & ~request_mask;
    end

    // Enabled pins never drive, whatever the direction bit says
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
            PIN_DRIVE_EN <= '0;
        else
            PIN_DRIVE_EN <= PORT_DIR & ~pin_enable_bits;
    end

endmodule : keyboard_interrupt_unit

//--- rtl/keyboard_interrupt_unit_cfg.svh
// Register map, field positions and reset values of the keypad wake unit
`ifndef KEYBOARD_INTERRUPT_UNIT_CFG_SVH
`define KEYBOARD_INTERRUPT_UNIT_CFG_SVH

`define KEY_STATUS_CONTROL_OFFSET 12'h000
`define KEY_PIN_ENABLE_OFFSET 12'h004
`define KEY_PIN_POLARITY_OFFSET 12'h008

`define SENSITIVITY_SELECT_BIT 0
`define REQUEST_MASK_BIT 1
`define REQUEST_ACKNOWLEDGE_BIT 2
`define PENDING_FLAG_BIT 3

`define SENSITIVITY_SELECT_RESET 1'b0
`define REQUEST_MASK_RESET 1'b0
`define KEY_PIN_ENABLE_RESET 8'h00
`define KEY_PIN_POLARITY_RESET 8'h00

`endif

//--- rtl/keyboard_interrupt_unit_pkg.sv
// Shared types of the keypad wake unit
package keyboard_interrupt_unit_pkg;

    typedef logic [31:0] apb_word_t;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_STATUS,
        SEL_ENABLE,
        SEL_POLARITY
    } reg_sel_t;

    typedef enum logic {
        SENSE_EDGE,
        SENSE_EDGE_LEVEL
    } sense_t;

endpackage : keyboard_interrupt_unit_pkg

//--- rtl/pin_sync.sv
// Two-flop synchroniser for one keypad input pin
`timescale 1ns/1ps
module pin_sync
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic d,
    output logic q
);
    logic meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : pin_sync

//--- rtl/key_pin_channel.sv
// Per-pin assertion decode and pull device selection
`timescale 1ns/1ps
module key_pin_channel
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic level,
    input wire logic enable,
    input wire logic polarity,
    output logic asserted,
    output logic pull_up,
    output logic pull_down
);
    // Polarity one asserts on high level, zero on low level
    assign asserted = enable & (level == polarity);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pull_up <= 1'b0;
            pull_down <= 1'b0;
        end
        else
        begin
            pull_up <= enable & ~polarity;
            pull_down <= enable & polarity;
        end
    end
endmodule : key_pin_channel

//--- sim/key_source_model.sv
// Switch model driving the keypad input pins
`timescale 1ns/1ps
module key_source_model
#(parameter int N = 5)
(
    input wire logic clk,
    input wire logic [N-1:0] drive,
    input wire logic [N-1:0] value,
    input wire logic [N-1:0] pull_up,
    input wire logic [N-1:0] pull_down,
    output logic [N-1:0] pins
);
    logic [N-1:0] wander;
    // Unpulled released pins wander so no settled guess is trusted
    initial
        wander = '0;
    always @(posedge clk)
        wander <= ~wander;
    always_comb
        for (int i = 0; i < N; i++)
            pins[i] = drive[i] ? value[i] : pull_up[i] ? 1'b1 :
                pull_down[i] ? 1'b0 : wander[i];
endmodule : key_source_model

//--- sim/key_unit_chk.sv
// Port assertions for the keypad wake unit
`timescale 1ns/1ps
module key_unit_chk
#(parameter int NUM_PINS = 5, parameter int ADDR_W = 12)
(
    input wire logic CLOCK, RST_B, PSEL, PENABLE, PWRITE, PSLVERR, KEY_IRQ,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [3:0] PSTRB,
    input wire keyboard_interrupt_unit_pkg::apb_word_t PWDATA, PRDATA,
    input wire logic [NUM_PINS-1:0] PORT_DIR, PULLUP_EN, PULLDOWN_EN,
    input wire logic [NUM_PINS-1:0] PIN_DRIVE_EN
);
    import keyboard_interrupt_unit_pkg::*;
    logic acc, rd, bad;
    assign acc = PSEL && PENABLE;
    assign rd = acc && !PWRITE;
    assign bad = !(PADDR inside {12'h0, 12'h4, 12'h8});
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    property p_err; acc && bad |-> PSLVERR; endproperty
    a_err: assert property (p_err) else $error("no error");
    property p_ok; PSLVERR |-> acc && bad; endproperty
    a_ok: assert property (p_ok) else $error("stray error");
    property p_hi; rd |-> PRDATA[31:8] == '0; endproperty
    a_hi: assert property (p_hi) else $error("upper bits set");
    property p_ack;
        rd && PADDR == 12'h0 |-> PRDATA[7:4] == '0 && !PRDATA[2];
    endproperty
    a_ack: assert property (p_ack) else $error("status bits");
    property p_pull; (PULLUP_EN & PULLDOWN_EN) == '0; endproperty
    a_pull: assert property (p_pull) else $error("both pulls");
    property p_drv; (PIN_DRIVE_EN & (PULLUP_EN | PULLDOWN_EN)) == '0;
    endproperty
    a_drv: assert property (p_drv) else $error("pin driven");
    property p_dir; (PIN_DRIVE_EN & ~$past(PORT_DIR)) == '0; endproperty
    a_dir: assert property (p_dir) else $error("drive no dir");
    // Mask lands at the access edge, the request one edge later
    property p_mask;
        acc && PWRITE && PSTRB[0] && PADDR == 12'h0 && PWDATA[1]
            |=> ##1 !KEY_IRQ;
    endproperty
    a_mask: assert property (p_mask) else $error("mask ignored");
    c_irq: cover property ($rose(KEY_IRQ));
    c_bad: cover property (acc && bad);
    c_drop: cover property (KEY_IRQ ##1 !KEY_IRQ);
endmodule : key_unit_chk
bind keyboard_interrupt_unit key_unit_chk
    #(.NUM_PINS(NUM_PINS), .ADDR_W(ADDR_W)) u_chk (.CLOCK, .RST_B, .PSEL,
    .PENABLE, .PWRITE, .PSLVERR, .KEY_IRQ, .PADDR, .PSTRB, .PWDATA, .PRDATA,
    .PORT_DIR, .PULLUP_EN, .PULLDOWN_EN, .PIN_DRIVE_EN);

//--- sim/keyboard_interrupt_unit_bench.sv
// Self-checking bench for the keypad wake unit
`timescale 1ns/1ps
module keyboard_interrupt_unit_bench;
    import keyboard_interrupt_unit_pkg::*;
    logic clock = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0;
    logic vf = 0, brk = 0, bce = 0, irq, rdy, err, ev;
    logic [11:0] pa = '0;
    apb_word_t pwd = '0, prd, rv;
    logic [4:0] dir = '0, drv = '1, val = '0, pins, pu, pd, de;
    int bad_count = 0, checked = 0, en = 0, pol = 0, mode = 0, mask = 0;
    int lat = 0, any = 0, pv = 0;
    logic [31:0] seed = 32'habd62ace;
    always #12.5 clock = ~clock;
    keyboard_interrupt_unit u_dut (.CLOCK(clock), .RST_B(rst_b),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
        .PWDATA(pwd), .PSTRB(4'h1), .PRDATA(prd), .PREADY(rdy),
        .PSLVERR(err), .KEYPAD_INPUT_PINS(pins), .PORT_DIR(dir),
        .VECTOR_FETCH(vf), .BREAK_STATE(brk), .BREAK_CLEAR_ENABLE(bce),
        .KEY_IRQ(irq), .PULLUP_EN(pu), .PULLDOWN_EN(pd), .PIN_DRIVE_EN(de));
    key_source_model u_src (.clk(clock), .drive(drv), .value(val),
        .pull_up(pu), .pull_down(pd), .pins(pins));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic stop_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic [11:0] a, input logic w, input int d);
        int n;
        n = 0;
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= 32'(d & 255);
        @(posedge clock);
        pen <= 1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (rdy !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            stop_test();
        end
        rv = prd;
        ev = err;
        psel <= 0;
        pen <= 0;
        @(posedge clock);
    endtask : apb
    task automatic upd();
        int a;
        a = (en & ~(pv ^ pol) & 31) != 0;
        if (a && !any)
            lat = 1;
        any = a;
    endtask : upd
    task automatic look();
        int p;
        repeat (4) @(posedge clock);
        p = lat | (mode & any);
        apb(12'h0, 0, 0);
        chk(rv, 32'(p * 8 + mask * 2 + mode));
        chk(irq, 32'(p & ~mask & 1));
        chk(pu, 32'(en & ~pol & 31));
        chk(pd, 32'(en & pol));
        chk(de, 32'(dir & ~5'(en)));
    endtask : look
    task automatic wst(input int m, input int d);
        mask = m;
        mode = d;
        apb(12'h0, 1, m * 2 + d);
    endtask : wst
    task automatic ack();
        apb(12'h0, 1, 4 + mask * 2 + mode);
        if (!brk || bce)
            lat = 0;
    endtask : ack
    task automatic wreg(input logic [11:0] a, input int v);
        apb(a, 1, v);
        if (a == 12'h4)
            en = v;
        else
            pol = v;
        upd();
    endtask : wreg
    task automatic pin(input int v);
        val <= 5'(v);
        pv = v;
        upd();
        repeat (6) @(posedge clock);
    endtask : pin
    initial
    begin
        repeat (10) @(posedge clock);
        rst_b <= 1;
        apb(12'h4, 0, 0);
        chk(rv, 0);
        apb(12'h8, 0, 0);
        chk(rv, 0);
        apb(12'hc, 0, 0);
        chk(ev, 1);
        look();
        wst(1, 0);
        wreg(12'h8, 'h0a);
        pin('h15);
        wreg(12'h4, 'h1f);
        ack();
        wst(0, 0);
        look();
        pin(pv ^ 1);
        look();
        wst(1, 0);
        look();
        wst(0, 0);
        ack();
        look();
        pin(pv ^ 2);
        look();
        pin('h15);
        pin(pv ^ 4);
        look();
        vf <= 1;
        @(posedge clock);
        vf <= 0;
        lat = 0;
        look();
        pin(pv ^ 8);
        brk <= 1;
        ack();
        look();
        bce <= 1;
        ack();
        brk <= 0;
        bce <= 0;
        look();
        wst(0, 1);
        pin('h15);
        ack();
        pin(pv ^ 16);
        look();
        ack();
        look();
        pin('h15);
        look();
        pin(pv ^ 1);
        pin('h15);
        ack();
        look();
        for (int k = 0; k < 40; k++)
        begin
            dir <= 5'(rnd());
            if (k % 8 == 0)
                wreg(12'h4, rnd() & 31);
            if (k % 8 == 4)
                wreg(12'h8, rnd() & 31);
            pin(rnd() & 31);
            if (k % 3 == 0)
                ack();
            look();
        end
        wreg(12'h4, 'h1f);
        pin(~pol & 31);
        ack();
        drv <= '0;
        look();
        rst_b <= 0;
        @(posedge clock);
        rst_b <= 1;
        {en, pol, mode, mask, lat, any} = '0;
        look();
        stop_test();
    end
endmodule : keyboard_interrupt_unit_bench
